/* common/irq_pkg.sv */
// Constants, register map and carrier types for the radio interrupt status block
package irq_pkg;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [7:0] IDX_STATUS_SYSTEM = 8'h0D;
  localparam logic [7:0] IDX_STATUS_RECEIVE = 8'h0E;
  localparam logic [7:0] IDX_ENABLE_SYSTEM = 8'h10;
  localparam logic [7:0] IDX_ENABLE_RECEIVE = 8'h11;
  localparam logic [7:0] IDX_CRC_ERR_H = 8'h13;
  localparam logic [7:0] IDX_CRC_ERR_M = 8'h14;
  localparam logic [7:0] IDX_CRC_ERR_L = 8'h15;
  localparam logic [7:0] IDX_TX_FIFO_HIGH = 8'h17;
  localparam logic [7:0] IDX_TX_FIFO_LOW = 8'h18;
  localparam logic [7:0] IDX_RX_FIFO_HIGH = 8'h19;
  localparam logic [7:0] IDX_RX_FIFO_LOW = 8'h1A;
  localparam logic [7:0] IDX_SLEEP_IRQ_CLEAR = 8'h75;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [5:0] FIFO_HIGH_RESET = 6'h30;
  localparam logic [5:0] FIFO_LOW_RESET = 6'h10;
  localparam logic [23:0] CRC_ERR_RESET = 24'h000000;
  localparam logic [31:0] HRDATA_RESET = 32'h00000000;

  // ************************************************************
  // Status bit positions, system group
  // ************************************************************
  localparam int B_LS_CAL = 7;
  localparam int B_WAKE_TIMER = 6;
  localparam int B_FIFO_FULL = 5;
  localparam int B_FIFO_EMPTY = 4;
  localparam int B_RF_STATE = 3;
  localparam int B_PLL_UNLOCK = 2;
  localparam int B_VCO_FUSE = 1;
  localparam int B_CLK_STABLE = 0;

  // ************************************************************
  // Status bit positions, receive group
  // ************************************************************
  localparam int B_SYNC_ERR = 7;
  localparam int B_FIELD_CHECK = 6;
  localparam int B_SYNC_DET = 5;
  localparam int B_RX_FIFO_ERR = 4;
  localparam int B_LEN_ERR = 3;
  localparam int B_DIVERSITY = 2;
  localparam int B_CRC_ERR = 1;
  localparam int B_RX_DONE = 0;

  // ************************************************************
  // Bus and misc
  // ************************************************************
  localparam logic HRESP_OKAY = 1'b0;
  localparam int CRC_BLOCKS = 24;

  // ************************************************************
  // Carrier types
  // ************************************************************
  typedef struct packed {
    logic ls_cal_done;
    logic wake_timer_done;
    logic rf_state_done;
    logic pll_unlock;
    logic vco_cal_done;
    logic fuse_access_done;
    logic clk_stable_done;
  } sys_evt_s;

  typedef struct packed {
    logic sync_lost;
    logic field_check;
    logic sync_detect;
    logic fifo_access_err;
    logic len_err;
    logic diversity_done;
    logic crc_err;
    logic multi_block;
    logic [4:0] crc_block;
    logic rx_done;
  } rx_evt_s;

  typedef struct packed {
    logic tx_active;
    logic rx_active;
    logic [6:0] level;
  } fifo_s;

  typedef enum logic [1:0] {
    PKT_IDLE = 2'b01,
    PKT_OPEN = 2'b10
  } pkt_state_e;

endpackage

/* verilog/irq_flag_bank.sv */
// Eight sticky status flags with immediate and deferred clear
module irq_flag_bank (
  // Clock, reset and enable
  input wire logic ref_clk,
  input wire logic hard_reset_n,
  input wire logic ce,
  // Events and clears
  input wire logic [7:0] set_vec,
  input wire logic [7:0] imm_clr,
  input wire logic [7:0] defer_clr,
  input wire logic apply_defer,
  // State
  output logic [7:0] status,
  output logic [7:0] pending
);

  logic [7:0] status_r;
  logic [7:0] status_nxt;
  logic [7:0] pending_r;
  logic [7:0] pending_nxt;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    status_nxt = (status_r & ~imm_clr & ~(apply_defer ? pending_r : 8'h00)) | set_vec;
    pending_nxt = apply_defer ? defer_clr : (pending_r | defer_clr);
  end

  always_ff @(posedge ref_clk) begin
    if (!hard_reset_n) begin
      status_r <= irq_pkg::STATUS_RESET;
    end else if (ce) begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!hard_reset_n) begin
      pending_r <= 8'h00;
    end else if (ce) begin
      pending_r <= pending_nxt;
    end
  end

  assign status = status_r;
  assign pending = pending_r;

endmodule // irq_flag_bank

/* verilog/radio_irq_status_grp1_grp2.sv */
// Interrupt status, enable and pin logic for the system and receive event groups
module radio_irq_status_grp1_grp2 (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic hard_reset_n,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Device events and state
  input wire irq_pkg::sys_evt_s sys_evt,
  input wire irq_pkg::rx_evt_s rx_evt,
  input wire irq_pkg::fifo_s fifo,
  input wire logic rx_fifo_mode,
  input wire logic asleep,
  // Interrupt pin
  output logic irq_n
);

  logic wr_act_r;
  logic [7:0] wr_idx_r;
  logic [31:0] hrdata_r;
  logic [31:0] rd_nxt;
  logic irq_n_r;
  logic [7:0] irq_enable_system_r;
  logic [7:0] irq_enable_receive_r;
  logic [5:0] tx_fifo_high_threshold_r;
  logic [5:0] tx_fifo_low_threshold_r;
  logic [5:0] rx_fifo_high_threshold_r;
  logic [5:0] rx_fifo_low_threshold_r;
  logic [23:0] crc_err_r;
  logic full_prev_r;
  logic empty_prev_r;
  logic wake_block_r;
  logic div_done_r;
  irq_pkg::pkt_state_e pkt_state_r;
  logic wr_now;
  logic wr_sys;
  logic wr_rx;
  logic wr_slp;
  logic [7:0] irq_status_system;
  logic [7:0] irq_status_receive;
  logic [7:0] pend_sys;
  logic [7:0] pend_rx;
  logic [7:0] set_sys;
  logic [7:0] set_rx;
  logic [7:0] imm_sys;
  logic [7:0] imm_rx;
  logic [7:0] dfr_sys;
  logic [7:0] dfr_rx;
  logic [5:0] hi_thr;
  logic [5:0] lo_thr;
  logic fifo_act;
  logic full_now;
  logic empty_now;
  logic full_hit;
  logic empty_hit;
  logic any_pend;

  // ************************************************************
  // Bus address phase
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (!hard_reset_n) begin
      wr_act_r <= 1'b0;
      wr_idx_r <= 8'h00;
    end else if (ce) begin
      wr_act_r <= hready && hsel && htrans[1] && hwrite;
      wr_idx_r <= haddr[9:2];
    end
  end

  always_comb begin
    unique case (haddr[9:2])
      irq_pkg::IDX_STATUS_SYSTEM: rd_nxt = {24'h000000, irq_status_system};
      irq_pkg::IDX_STATUS_RECEIVE: rd_nxt = {24'h000000, irq_status_receive};
      irq_pkg::IDX_ENABLE_SYSTEM: rd_nxt = {24'h000000, irq_enable_system_r};
      irq_pkg::IDX_ENABLE_RECEIVE: rd_nxt = {24'h000000, irq_enable_receive_r};
      irq_pkg::IDX_CRC_ERR_H: rd_nxt = {24'h000000, crc_err_r[23:16]};
      irq_pkg::IDX_CRC_ERR_M: rd_nxt = {24'h000000, crc_err_r[15:8]};
      irq_pkg::IDX_CRC_ERR_L: rd_nxt = {24'h000000, crc_err_r[7:0]};
      irq_pkg::IDX_TX_FIFO_HIGH: rd_nxt = {26'h0000000, tx_fifo_high_threshold_r};
      irq_pkg::IDX_TX_FIFO_LOW: rd_nxt = {26'h0000000, tx_fifo_low_threshold_r};
      irq_pkg::IDX_RX_FIFO_HIGH: rd_nxt = {26'h0000000, rx_fifo_high_threshold_r};
      irq_pkg::IDX_RX_FIFO_LOW: rd_nxt = {26'h0000000, rx_fifo_low_threshold_r};
      default: rd_nxt = 32'h00000000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!hard_reset_n) begin
      hrdata_r <= irq_pkg::HRDATA_RESET;
    end else if (ce && hready && hsel && htrans[1] && !hwrite) begin
      hrdata_r <= rd_nxt;
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = ce;
  assign hresp = irq_pkg::HRESP_OKAY;

  // ************************************************************
  // Bus data phase writes
  // ************************************************************
  assign wr_now = wr_act_r && ce;
  assign wr_sys = wr_now && (wr_idx_r == irq_pkg::IDX_STATUS_SYSTEM);
  assign wr_rx = wr_now && (wr_idx_r == irq_pkg::IDX_STATUS_RECEIVE);
  assign wr_slp = wr_now && (wr_idx_r == irq_pkg::IDX_SLEEP_IRQ_CLEAR);

  always_comb begin
    imm_sys = 8'h00;
    imm_rx = 8'h00;
    dfr_sys = 8'h00;
    dfr_rx = 8'h00;
    if (wr_sys && !asleep) begin
      imm_sys = ~hwdata[7:0];
    end
    if (wr_rx && !asleep) begin
      imm_rx = ~hwdata[7:0];
    end
    if (wr_sys && asleep) begin
      dfr_sys = ~hwdata[7:0];
    end
    if (wr_rx && asleep) begin
      dfr_rx = ~hwdata[7:0];
    end
    if (wr_slp) begin
      imm_sys = imm_sys | hwdata[7:0];
      imm_rx = imm_rx | hwdata[15:8];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!hard_reset_n) begin
      irq_enable_system_r <= irq_pkg::ENABLE_RESET;
      irq_enable_receive_r <= irq_pkg::ENABLE_RESET;
    end else if (wr_now) begin
      if (wr_idx_r == irq_pkg::IDX_ENABLE_SYSTEM) begin
        irq_enable_system_r <= hwdata[7:0];
      end
      if (wr_idx_r == irq_pkg::IDX_ENABLE_RECEIVE) begin
        irq_enable_receive_r <= hwdata[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!hard_reset_n) begin
      tx_fifo_high_threshold_r <= irq_pkg::FIFO_HIGH_RESET;
      tx_fifo_low_threshold_r <= irq_pkg::FIFO_LOW_RESET;
      rx_fifo_high_threshold_r <= irq_pkg::FIFO_HIGH_RESET;
      rx_fifo_low_threshold_r <= irq_pkg::FIFO_LOW_RESET;
    end else if (wr_now) begin
      if (wr_idx_r == irq_pkg::IDX_TX_FIFO_HIGH) begin
        tx_fifo_high_threshold_r <= hwdata[5:0];
      end
      if (wr_idx_r == irq_pkg::IDX_TX_FIFO_LOW) begin
        tx_fifo_low_threshold_r <= hwdata[5:0];
      end
      if (wr_idx_r == irq_pkg::IDX_RX_FIFO_HIGH) begin
        rx_fifo_high_threshold_r <= hwdata[5:0];
      end
      if (wr_idx_r == irq_pkg::IDX_RX_FIFO_LOW) begin
        rx_fifo_low_threshold_r <= hwdata[5:0];
      end
    end
  end

  // ************************************************************
  // FIFO threshold crossings
  // ************************************************************
  assign hi_thr = fifo.tx_active ? tx_fifo_high_threshold_r : rx_fifo_high_threshold_r;
  assign lo_thr = fifo.tx_active ? tx_fifo_low_threshold_r : rx_fifo_low_threshold_r;
  assign fifo_act = fifo.tx_active || fifo.rx_active;
  assign full_now = fifo_act && (fifo.level >= {1'b0, hi_thr});
  assign empty_now = fifo_act && (fifo.level < {1'b0, lo_thr});
  assign full_hit = full_now && !full_prev_r;
  assign empty_hit = empty_now && !empty_prev_r;

  always_ff @(posedge ref_clk) begin
    if (!hard_reset_n) begin
      full_prev_r <= 1'b0;
      empty_prev_r <= 1'b0;
    end else if (ce) begin
      full_prev_r <= full_now;
      empty_prev_r <= empty_now;
    end
  end

  // ************************************************************
  // Receive sequencing
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (!hard_reset_n) begin
      pkt_state_r <= irq_pkg::PKT_IDLE;
    end else if (ce) begin
      unique case (pkt_state_r)
        irq_pkg::PKT_IDLE: begin
          if (rx_evt.sync_detect && !rx_evt.rx_done) begin
            pkt_state_r <= irq_pkg::PKT_OPEN;
          end
        end
        irq_pkg::PKT_OPEN: begin
          if (rx_evt.rx_done || rx_evt.sync_lost) begin
            pkt_state_r <= irq_pkg::PKT_IDLE;
          end
        end
        default: pkt_state_r <= irq_pkg::PKT_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!hard_reset_n) begin
      div_done_r <= 1'b0;
    end else if (ce) begin
      if (rx_evt.sync_detect) begin
        div_done_r <= 1'b0;
      end else if (rx_evt.diversity_done) begin
        div_done_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!hard_reset_n) begin
      crc_err_r <= irq_pkg::CRC_ERR_RESET;
    end else if (ce) begin
      if (rx_evt.crc_err && rx_evt.multi_block && (rx_evt.crc_block < 5'd24)) begin
        crc_err_r[rx_evt.crc_block] <= 1'b1;
      end else if (rx_evt.sync_detect) begin
        crc_err_r <= irq_pkg::CRC_ERR_RESET;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!hard_reset_n) begin
      wake_block_r <= 1'b0;
    end else if (ce) begin
      if (dfr_sys[irq_pkg::B_WAKE_TIMER]) begin
        wake_block_r <= 1'b1;
      end else if (sys_evt.clk_stable_done) begin
        wake_block_r <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Event sets and flag banks
  // ************************************************************
  always_comb begin
    set_sys = 8'h00;
    set_sys[irq_pkg::B_LS_CAL] = sys_evt.ls_cal_done;
    set_sys[irq_pkg::B_WAKE_TIMER] = sys_evt.wake_timer_done && !wake_block_r;
    set_sys[irq_pkg::B_FIFO_FULL] = full_hit;
    set_sys[irq_pkg::B_FIFO_EMPTY] = empty_hit;
    set_sys[irq_pkg::B_RF_STATE] = sys_evt.rf_state_done;
    set_sys[irq_pkg::B_PLL_UNLOCK] = sys_evt.pll_unlock;
    set_sys[irq_pkg::B_VCO_FUSE] = sys_evt.vco_cal_done || sys_evt.fuse_access_done;
    set_sys[irq_pkg::B_CLK_STABLE] = sys_evt.clk_stable_done;
    set_rx = 8'h00;
    set_rx[irq_pkg::B_SYNC_ERR] = rx_evt.sync_lost && (pkt_state_r == irq_pkg::PKT_OPEN);
    set_rx[irq_pkg::B_FIELD_CHECK] = rx_evt.field_check;
    set_rx[irq_pkg::B_SYNC_DET] = rx_evt.sync_detect;
    set_rx[irq_pkg::B_RX_FIFO_ERR] = rx_evt.fifo_access_err && rx_fifo_mode;
    set_rx[irq_pkg::B_LEN_ERR] = rx_evt.len_err;
    set_rx[irq_pkg::B_DIVERSITY] = rx_evt.sync_detect && (div_done_r || rx_evt.diversity_done);
    set_rx[irq_pkg::B_CRC_ERR] = rx_evt.crc_err;
    set_rx[irq_pkg::B_RX_DONE] = rx_evt.rx_done;
  end

  irq_flag_bank u_bank_sys (
    .ref_clk(ref_clk),
    .hard_reset_n(hard_reset_n),
    .ce(ce),
    .set_vec(set_sys),
    .imm_clr(imm_sys),
    .defer_clr(dfr_sys),
    .apply_defer(sys_evt.clk_stable_done),
    .status(irq_status_system),
    .pending(pend_sys)
  );

  irq_flag_bank u_bank_rx (
    .ref_clk(ref_clk),
    .hard_reset_n(hard_reset_n),
    .ce(ce),
    .set_vec(set_rx),
    .imm_clr(imm_rx),
    .defer_clr(dfr_rx),
    .apply_defer(sys_evt.clk_stable_done),
    .status(irq_status_receive),
    .pending(pend_rx)
  );

  // ************************************************************
  // Interrupt pin
  // ************************************************************
  assign any_pend = |(irq_status_system & irq_enable_system_r) | |(irq_status_receive & irq_enable_receive_r);

  always_ff @(posedge ref_clk) begin
    if (!hard_reset_n) begin
      irq_n_r <= 1'b1;
    end else if (ce) begin
      irq_n_r <= !any_pend;
    end
  end

  assign irq_n = irq_n_r;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!hard_reset_n);

  sequence s_pkt_open;
    ce && rx_evt.sync_detect && !rx_evt.rx_done && !rx_evt.sync_lost;
  endsequence

  sequence s_lost_inside;
    ce && rx_evt.sync_lost && !rx_evt.rx_done;
  endsequence

  a_ls_cal_set: assert property (ce && sys_evt.ls_cal_done |=> irq_status_system[7])
    else $error("calibration event not recorded");
  a_wake_block: assert property (ce && sys_evt.wake_timer_done && wake_block_r && !irq_status_system[6]
    && !(wr_slp && hwdata[6]) |=> !irq_status_system[6])
    else $error("wake timer event raised after sleep clear");
  a_fifo_full: assert property (ce && fifo.tx_active && !full_prev_r
    && fifo.level >= {1'b0, tx_fifo_high_threshold_r} |=> irq_status_system[5])
    else $error("fifo high threshold not flagged");
  a_fifo_empty: assert property (ce && fifo.rx_active && !fifo.tx_active && !empty_prev_r
    && fifo.level < {1'b0, rx_fifo_low_threshold_r} |=> irq_status_system[4])
    else $error("fifo low threshold not flagged");
  a_clk_stable: assert property (ce && sys_evt.clk_stable_done |=> irq_status_system[0])
    else $error("clock stable not flagged");
  a_fuse_set: assert property (ce && sys_evt.fuse_access_done |=> irq_status_system[1])
    else $error("fuse access not flagged");
  a_mask_free: assert property (ce && rx_evt.rx_done && irq_enable_receive_r == 8'h00
    |=> irq_status_receive[0])
    else $error("masked event not shown in status");
  a_write_one: assert property (ce && wr_rx && !asleep && hwdata[3] && irq_status_receive[3]
    && !(sys_evt.clk_stable_done && pend_rx[3]) |=> irq_status_receive[3])
    else $error("writing one cleared a flag");
  a_zero_clear: assert property (ce && wr_rx && !asleep && !hwdata[6] && !rx_evt.field_check
    |=> !irq_status_receive[6])
    else $error("writing zero did not clear");
  a_sleep_defer: assert property (ce && wr_sys && asleep && !hwdata[3] && irq_status_system[3]
    && !sys_evt.clk_stable_done && !(wr_slp && hwdata[3])
    |=> irq_status_system[3] && pend_sys[3])
    else $error("sleep clear applied early");
  a_defer_apply: assert property (ce && pend_rx[5] && sys_evt.clk_stable_done && !rx_evt.sync_detect
    |=> !irq_status_receive[5])
    else $error("deferred clear not applied");
  a_sleep_reg: assert property (ce && wr_slp && hwdata[8] && !rx_evt.rx_done
    |=> !irq_status_receive[0])
    else $error("sleep clear register did not clear");
  a_sync_lost: assert property (s_pkt_open ##1 s_lost_inside |=> irq_status_receive[7])
    else $error("sync loss in packet not flagged");
  a_diversity: assert property (ce && rx_evt.diversity_done && !rx_evt.sync_detect
    ##1 ce && rx_evt.sync_detect |=> irq_status_receive[2])
    else $error("diversity not flagged at sync");
  a_rx_fifo_err: assert property (ce && rx_evt.fifo_access_err && !rx_fifo_mode
    && !irq_status_receive[4] && pend_rx == 8'h00 |=> !irq_status_receive[4])
    else $error("fifo error flagged outside fifo mode");
  a_pin_low: assert property (ce && any_pend |=> !irq_n)
    else $error("pin not low with pending event");
  a_pin_high: assert property (ce && !any_pend |=> irq_n)
    else $error("pin not released");

endmodule // radio_irq_status_grp1_grp2

/* bench/host_model.sv */
// Host bus master model issuing single AHB-Lite word transfers
module host_model (
  // Clock
  input wire logic clk,
  // Bus requests
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  // Bus answers
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Wait bound used up
  output logic tmo
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {hsel, haddr, htrans, hwrite, hsize, hwdata, tmo} = '0;
  // ************
  // Bus phases
  // ************
  task automatic wt();
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) tmo <= 1'b1;
  endtask
  task automatic xfer(input logic w, input logic [7:0] i, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    haddr <= {22'h0, i, 2'h0};
    wt();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    q = hrdata;
  endtask
endmodule // host_model

/* bench/tb_radio_irq_status_grp1_grp2.sv */
// Self-checking testbench for the radio interrupt status block
module tb_radio_irq_status_grp1_grp2;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, hard_reset_n = 1'b0, ce = 1'b1, rx_fifo_mode = 1'b1, asleep = 1'b0, en = 1'b0;
  irq_pkg::sys_evt_s sys_evt = '0;
  irq_pkg::rx_evt_s rx_evt = '0;
  irq_pkg::fifo_s fifo = '0;
  logic hsel, hwrite, hreadyout, hresp, irq_n, tmo;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  int error_cnt = 0;
  int samples_checked = 0;
  radio_irq_status_grp1_grp2 i_dut (.ref_clk(ref_clk), .hard_reset_n(hard_reset_n), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sys_evt(sys_evt), .rx_evt(rx_evt), .fifo(fifo),
    .rx_fifo_mode(rx_fifo_mode), .asleep(asleep), .irq_n(irq_n));
  host_model i_host (.clk(ref_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .tmo(tmo));
  // ************
  // Helpers
  // ************
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    logic [31:0] q;
    i_host.xfer(1'b1, i, d, q);
  endtask
  task automatic rd(input logic [7:0] i, input logic [31:0] e);
    logic [31:0] q;
    i_host.xfer(1'b0, i, 32'h0, q);
    chk(q, e);
  endtask
  task automatic pulse(input logic [6:0] v);
    @(posedge ref_clk);
    sys_evt <= v;
    @(posedge ref_clk);
    sys_evt <= '0;
  endtask
  task automatic ev(input int k, input logic [13:0] v, input logic [7:0] e);
    logic [7:0] i;
    i = (k == 1) ? 8'h0E : 8'h0D;
    @(posedge ref_clk);
    if (k == 0) sys_evt <= v[6:0];
    else if (k == 1) rx_evt <= v;
    else fifo <= v[8:0];
    @(posedge ref_clk);
    sys_evt <= '0;
    rx_evt <= '0;
    rd(i, {24'h0, e});
    chk(irq_n, !(en && e != 8'h00));
    wr(i, {24'h0, ~e});
    rd(i, 32'h0);
    chk(irq_n, 1'b1);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ************
  // Sequence
  // ************
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge tmo) begin
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    hard_reset_n <= 1'b1;
    rd(8'h0D, 32'h0);
    rd(8'h0E, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'h19, 32'h30);
    rd(8'h1A, 32'h10);
    wr(8'h3F, 32'hFF);
    rd(8'h3F, 32'h0);
    rd(8'h75, 32'h0);
    chk(irq_n, 1'b1);
    chk(hresp, 1'b0);
    $display("reset test done");
    ev(0, 14'h40, 8'h80);
    ev(0, 14'h20, 8'h40);
    ev(0, 14'h10, 8'h08);
    ev(0, 14'h08, 8'h04);
    ev(0, 14'h02, 8'h02);
    wr(8'h0D, 32'hFD);
    ev(0, 14'h04, 8'h02);
    ev(0, 14'h01, 8'h01);
    ev(1, 14'h1000, 8'h40);
    ev(1, 14'h0100, 8'h00);
    ev(1, 14'h0800, 8'h24);
    ev(1, 14'h2000, 8'h80);
    ev(1, 14'h2000, 8'h00);
    ev(1, 14'h0200, 8'h08);
    ev(1, 14'h00C6, 8'h02);
    rd(8'h15, 32'h08);
    ev(1, 14'h0001, 8'h01);
    ev(1, 14'h0400, 8'h10);
    rx_fifo_mode <= 1'b0;
    ev(1, 14'h0400, 8'h00);
    $display("event test done");
    wr(8'h17, 32'h05);
    wr(8'h18, 32'h02);
    ev(2, 14'h103, 8'h00);
    ev(2, 14'h105, 8'h20);
    ev(2, 14'h101, 8'h10);
    ev(2, 14'h000, 8'h00);
    ev(2, 14'h085, 8'h10);
    ev(2, 14'h0B0, 8'h20);
    ev(2, 14'h000, 8'h00);
    $display("fifo test done");
    wr(8'h10, 32'hFF);
    wr(8'h11, 32'hFF);
    rd(8'h11, 32'hFF);
    en = 1'b1;
    ev(0, 14'h10, 8'h08);
    ev(1, 14'h0001, 8'h01);
    $display("mask test done");
    pulse(7'h50);
    asleep <= 1'b1;
    wr(8'h0D, 32'h3F);
    wr(8'h75, 32'h08);
    rd(8'h0D, 32'h80);
    chk(irq_n, 1'b0);
    pulse(7'h20);
    rd(8'h0D, 32'h80);
    asleep <= 1'b0;
    pulse(7'h01);
    rd(8'h0D, 32'h01);
    wr(8'h0D, 32'h00);
    rd(8'h0D, 32'h00);
    chk(irq_n, 1'b1);
    $display("sleep test done");
    pulse(7'h10);
    @(posedge ref_clk);
    rx_evt <= 14'h0300;
    @(posedge ref_clk);
    rx_evt <= 14'h0800;
    @(posedge ref_clk);
    rx_evt <= 14'h2000;
    @(posedge ref_clk);
    rx_evt <= '0;
    asleep <= 1'b1;
    wr(8'h0E, 32'hDF);
    wr(8'h0D, 32'hF7);
    wr(8'h75, 32'h8100);
    rd(8'h0E, 32'h2C);
    rd(8'h0D, 32'h08);
    chk(irq_n, 1'b0);
    asleep <= 1'b0;
    pulse(7'h01);
    rd(8'h0E, 32'h0C);
    rd(8'h0D, 32'h01);
    wr(8'h0E, 32'hFB);
    rd(8'h0E, 32'h08);
    wr(8'h0E, 32'h00);
    wr(8'h0D, 32'h00);
    rd(8'h0E, 32'h00);
    chk(irq_n, 1'b1);
    $display("deferred receive test done");
    ce <= 1'b0;
    pulse(7'h40);
    chk(hreadyout, 1'b0);
    ce <= 1'b1;
    rd(8'h0D, 32'h00);
    $display("clock enable test done");
    tally_and_finish();
  end
endmodule // tb_radio_irq_status_grp1_grp2
